//--- rtl/dcc_channel.sv
/*
 dcc_channel: one dma channel with its configuration, count, address and flag registers.
 assumes a register port with one-cycle strobes, a peripheral request level, and a
 system bus that acknowledges each access; channel arbitration lives outside.
*/
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module dcc_channel (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic [4:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire logic                  periph_req,
  input  wire logic                  grant,
  input  wire logic                  bus_ack,
  input  wire logic                  bus_err,
  input  wire logic [31:0]           bus_rdata,
  output dcc_pkg::dcc_bus_req_t      bus_req,
  output logic                       bus_valid,
  output logic [31:0]                bus_wdata,
  output logic                       chan_request,
  output logic [1:0]                 channel_priority,
  output logic                       irq
);
  import dcc_pkg::*;

  dcc_cfg_t                cfg;
  logic [31:0]             periph_base_addr;
  logic [31:0]             mem_base_addr;
  logic [31:0]             periph_ptr;
  logic [31:0]             mem_ptr;
  logic [3:0]              flag_status_reg;
  logic [CNT_BITS-1:0]     remaining_count;
  logic [CNT_BITS-1:0]     programmed;
  logic                    half_hit;
  logic                    done_hit;
  logic                    mv_busy;
  logic                    mv_finish;
  logic                    mv_fault;
  logic                    start;
  logic                    cnt_load;
  logic                    wr_cfg;
  logic [31:0]             src_addr;
  logic [31:0]             dst_addr;
  logic [1:0]              src_width;
  logic [1:0]              dst_width;
  logic [3:0]              clr;
  logic [3:0]              set;
  logic                    dbus_valid;
  dcc_bus_req_t            dbus_req;
  logic [31:0]             dbus_wdata;

  always_comb begin
    wr_cfg   = reg_wr && reg_addr == {1'b0, OFS_CONFIG};
    cnt_load = reg_wr && reg_addr == {1'b0, OFS_COUNT} && !cfg.enable; // R12 R13
  end

  // configuration; a fault drops enable even on a simultaneous config write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg <= '0; // R1
    end else begin
      if (wr_cfg) begin
        cfg.enable            <= reg_wdata[CFG_EN]; // R1
        cfg.done_irq_on       <= reg_wdata[CFG_DONE_IE]; // R2
        cfg.half_irq_on       <= reg_wdata[CFG_HALF_IE]; // R2
        cfg.fault_irq_on      <= reg_wdata[CFG_FAULT_IE]; // R2
        cfg.dir_from_mem      <= reg_wdata[CFG_DIR]; // R3
        cfg.auto_reload_mode  <= reg_wdata[CFG_AUTO_RELOAD_MODE]; // R4
        cfg.periph_addr_step  <= reg_wdata[CFG_PSTEP]; // R5
        cfg.mem_addr_step     <= reg_wdata[CFG_MSTEP]; // R6
        cfg.periph_elem_width <= reg_wdata[CFG_PW_LO+:2]; // R7
        cfg.mem_elem_width    <= reg_wdata[CFG_MW_LO+:2]; // R8
        cfg.channel_priority  <= reg_wdata[CFG_PRI_LO+:2]; // R9
        cfg.m2m_mode          <= reg_wdata[CFG_M2M]; // R10 R23
      end
      if (mv_fault) begin
        cfg.enable <= 1'b0; // R25
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      periph_base_addr <= RST_WORD;
      mem_base_addr    <= RST_WORD;
    end else if (reg_wr) begin
      if (reg_addr == {1'b0, OFS_PADDR}) begin
        periph_base_addr <= reg_wdata;
      end
      if (reg_addr == {1'b0, OFS_MADDR}) begin
        mem_base_addr <= reg_wdata;
      end
    end
  end

  // working pointers restart from the base on enable and on each block wrap
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      periph_ptr <= RST_WORD;
      mem_ptr    <= RST_WORD;
    end else if (!cfg.enable || (mv_finish && done_hit && cfg.auto_reload_mode)) begin
      periph_ptr <= dcc_align(periph_base_addr, cfg.periph_elem_width); // R17 R18
      mem_ptr    <= dcc_align(mem_base_addr, cfg.mem_elem_width); // R19 R20
    end else if (mv_finish) begin
      if (cfg.periph_addr_step) begin
        periph_ptr <= periph_ptr + dcc_step(cfg.periph_elem_width); // R5
      end
      if (cfg.mem_addr_step) begin
        mem_ptr <= mem_ptr + dcc_step(cfg.mem_elem_width); // R6
      end
    end
  end

  dcc_counter u_counter (
    .core_clk        (core_clk),
    .rst             (rst),
    .load            (cnt_load),
    .load_val        (reg_wdata[CNT_BITS-1:0]),
    .step            (mv_finish),
    .circular        (cfg.auto_reload_mode),
    .remaining_count (remaining_count),
    .programmed      (programmed),
    .half_hit        (half_hit),
    .done_hit        (done_hit)
  );

  always_comb begin
    // memory-to-memory uses the peripheral side as the second memory area
    src_width = cfg.dir_from_mem ? cfg.mem_elem_width : cfg.periph_elem_width;
    dst_width = cfg.dir_from_mem ? cfg.periph_elem_width : cfg.mem_elem_width;
    // aligned again at use: the enable edge reloads pointers with the old width
    src_addr  = dcc_align(cfg.dir_from_mem ? mem_ptr : periph_ptr, src_width); // R3 R17 R18 R19 R20
    dst_addr  = dcc_align(cfg.dir_from_mem ? periph_ptr : mem_ptr, dst_width); // R3 R17 R18 R19 R20
    start     = grant && chan_request && !mv_busy;
  end

  dcc_mover u_mover (
    .core_clk  (core_clk),
    .rst       (rst),
    .start     (start),
    .src_addr  (src_addr),
    .src_width (src_width),
    .dst_addr  (dst_addr),
    .dst_width (dst_width),
    .bus_ack   (bus_ack),
    .bus_err   (bus_err),
    .bus_rdata (bus_rdata),
    .bus_req   (dbus_req),
    .bus_valid (dbus_valid),
    .bus_wdata (dbus_wdata),
    .busy      (mv_busy),
    .finish    (mv_finish),
    .fault     (mv_fault)
  );

  // registered copies keep top outputs straight from flops; costs one cycle per phase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_req   <= '0;
      bus_valid <= 1'b0;
      bus_wdata <= 32'h0;
    end else begin
      bus_req   <= dbus_req;
      bus_valid <= dbus_valid && !bus_ack;
      bus_wdata <= dbus_wdata;
    end
  end

  // request is dropped while a transfer is in flight so the arbiter can rotate
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chan_request     <= 1'b0;
      channel_priority <= 2'h0;
    end else begin
      chan_request     <= cfg.enable && remaining_count != 16'h0 && !mv_busy && !start && !mv_finish
                          && !mv_fault && (cfg.m2m_mode || periph_req); // R16 R10 R25
      channel_priority <= cfg.channel_priority; // R9
    end
  end

  always_comb begin
    clr = 4'h0;
    if (reg_wr && reg_addr == OFS_CLEAR_W) begin
      clr = reg_wdata[3:0];
      if (reg_wdata[FLG_ANY]) begin
        clr = 4'hf; // R22
      end
    end
    set             = 4'h0;
    set[FLG_DONE]   = mv_finish && done_hit;
    set[FLG_HALF]   = mv_finish && half_hit;
    set[FLG_FAULT]  = mv_fault;
    set[FLG_ANY]    = |set[3:1];
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_status_reg <= 4'h0;
    end else begin
      flag_status_reg <= (flag_status_reg & ~clr) | set; // R21 R24
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (flag_status_reg[FLG_DONE] && cfg.done_irq_on)
          || (flag_status_reg[FLG_HALF] && cfg.half_irq_on)
          || (flag_status_reg[FLG_FAULT] && cfg.fault_irq_on); // R2
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          {1'b0, OFS_CONFIG}: reg_rdata <= {17'h0, cfg.m2m_mode, cfg.channel_priority, cfg.mem_elem_width,
                                            cfg.periph_elem_width, cfg.mem_addr_step, cfg.periph_addr_step,
                                            cfg.auto_reload_mode, cfg.dir_from_mem, cfg.fault_irq_on,
                                            cfg.half_irq_on, cfg.done_irq_on, cfg.enable}; // R1 R23
          {1'b0, OFS_COUNT}:  reg_rdata <= {16'h0, remaining_count}; // R13
          {1'b0, OFS_PADDR}:  reg_rdata <= periph_base_addr;
          {1'b0, OFS_MADDR}:  reg_rdata <= mem_base_addr;
          OFS_STATUS_W:       reg_rdata <= {28'h0, flag_status_reg};
          default:            reg_rdata <= 32'h0;
        endcase
      end
    end
  end
endmodule

//--- rtl/dcc_pkg.sv
/*
 dcc_pkg: register map, field positions, encodings and carrier types for one dma channel.
 assumes a single core clock; shared by the channel top and its two helper modules.
*/
// Behaviour
// R1 - config bit 0 enables the channel; resets to zero
// R2 - config bits 1..3 enable complete, half and error interrupts
// R3 - config bit 4: zero peripheral-to-memory, one memory-to-peripheral
// R4 - config bit 5 selects circular mode with count reload
// R5 - config bit 6 steps the peripheral address per transfer
// R6 - config bit 7 steps the memory address per transfer
// R7 - bits 9:8 peripheral width: 00 8 bit, 01 16 bit, 10 32 bit
// R8 - bits 11:10 memory width, same codes
// R9 - bits 13:12 priority low, medium, high, very high
// R10 - config bit 14 selects memory-to-memory mode, no peripheral request needed
// R11 - transfer count occupies bits 15:0, range 0 to 65535
// R12 - count writes accepted only while disabled; software programs count first
// R13 - while enabled count is read-only and shows elements remaining
// R14 - count decrements by one per completed element
// R15 - at block end count stays zero, or reloads when circular
// R16 - zero count means no transaction, enabled or not
// R17 - 16 bit peripheral width ignores address bit 0
// R18 - 32 bit peripheral width ignores address bits 1:0
// R19 - 16 bit memory width ignores address bit 0
// R20 - 32 bit memory width ignores address bits 1:0
// R21 - hardware sets flags; writing one to clear bit clears it
// R22 - clear-all bit clears global, error, half and complete flags together
// R23 - bit 14 one enables memory-to-memory, zero disables
// R24 - half flag at half the count moved, complete flag at zero
// R25 - bus fault raises error flag and disables the channel
package dcc_pkg;
  localparam logic [3:0]  OFS_CONFIG   = 4'h0;
  localparam logic [3:0]  OFS_COUNT    = 4'h4;
  localparam logic [3:0]  OFS_PADDR    = 4'h8;
  localparam logic [3:0]  OFS_MADDR    = 4'hc;
  localparam logic [4:0]  OFS_STATUS_W = 5'h10;
  localparam logic [4:0]  OFS_CLEAR_W  = 5'h14;
  localparam int          CFG_EN       = 0;
  localparam int          CFG_DONE_IE  = 1;
  localparam int          CFG_HALF_IE  = 2;
  localparam int          CFG_FAULT_IE = 3;
  localparam int          CFG_DIR      = 4;
  localparam int          CFG_AUTO_RELOAD_MODE     = 5;
  localparam int          CFG_PSTEP    = 6;
  localparam int          CFG_MSTEP    = 7;
  localparam int          CFG_PW_LO    = 8;
  localparam int          CFG_MW_LO    = 10;
  localparam int          CFG_PRI_LO   = 12;
  localparam int          CFG_M2M      = 14;
  localparam int          CFG_BITS     = 15;
  localparam int          CNT_BITS     = 16;
  localparam int          FLG_ANY      = 0;
  localparam int          FLG_DONE     = 1;
  localparam int          FLG_HALF     = 2;
  localparam int          FLG_FAULT    = 3;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  localparam logic [1:0]  W8           = 2'h0;
  localparam logic [1:0]  W16          = 2'h1;
  localparam logic [1:0]  W32          = 2'h2;

  typedef struct packed {
    logic [1:0] channel_priority;
    logic       m2m_mode;
    logic [1:0] mem_elem_width;
    logic [1:0] periph_elem_width;
    logic       mem_addr_step;
    logic       periph_addr_step;
    logic       auto_reload_mode;
    logic       dir_from_mem;
    logic       fault_irq_on;
    logic       half_irq_on;
    logic       done_irq_on;
    logic       enable;
  } dcc_cfg_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  width;
    logic        write;
  } dcc_bus_req_t;

  typedef struct packed {
    logic fault;
    logic done;
    logic half;
  } dcc_evt_t;

  // clear low address bits according to element width
  function automatic logic [31:0] dcc_align(input logic [31:0] a, input logic [1:0] w);
    logic [31:0] r;
    r = a;
    if (w == W16) begin
      r[0] = 1'b0;
    end else if (w == W32) begin
      r[1:0] = 2'h0;
    end
    return r;
  endfunction

  function automatic logic [31:0] dcc_step(input logic [1:0] w);
    logic [31:0] r;
    r = 32'h1;
    if (w == W16) begin
      r = 32'h2;
    end else if (w == W32) begin
      r = 32'h4;
    end
    return r;
  endfunction
endpackage

//--- rtl/dcc_counter.sv
/*
 dcc_counter: transfer count with reload, half and done detection.
 assumes load and step never coincide; the top only loads while disabled.
*/
`timescale 1ns/1ps
module dcc_counter (
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  input  wire logic                          load,
  input  wire logic [dcc_pkg::CNT_BITS-1:0]  load_val,
  input  wire logic                          step,
  input  wire logic                          circular,
  output logic      [dcc_pkg::CNT_BITS-1:0]  remaining_count,
  output logic      [dcc_pkg::CNT_BITS-1:0]  programmed,
  output logic                               half_hit,
  output logic                               done_hit
);
  import dcc_pkg::*;

  logic [CNT_BITS-1:0] next_count;

  always_comb begin
    next_count = remaining_count - 16'h1; // R14
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      programmed <= 16'h0;
    end else if (load) begin
      programmed <= load_val;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      remaining_count <= 16'h0;
    end else if (load) begin
      remaining_count <= load_val; // R11
    end else if (step && remaining_count != 16'h0) begin
      if (next_count == 16'h0 && circular) begin
        remaining_count <= programmed; // R15 R4
      end else begin
        remaining_count <= next_count; // R14 R15
      end
    end
  end

  // one-cycle pulses, aligned with the step that causes them
  always_comb begin
    half_hit = step && remaining_count != 16'h0 && next_count == (programmed >> 1) && programmed > 16'h1; // R24
    done_hit = step && remaining_count == 16'h1; // R24
  end
endmodule

//--- rtl/dcc_mover.sv
/*
 dcc_mover: one element transfer, read phase then write phase, on a simple request/ack bus.
 assumes the bus answers each access with ack and optional err in one pulse.
*/
`timescale 1ns/1ps
module dcc_mover (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  start,
  input  wire logic [31:0]           src_addr,
  input  wire logic [1:0]            src_width,
  input  wire logic [31:0]           dst_addr,
  input  wire logic [1:0]            dst_width,
  input  wire logic                  bus_ack,
  input  wire logic                  bus_err,
  input  wire logic [31:0]           bus_rdata,
  output dcc_pkg::dcc_bus_req_t      bus_req,
  output logic                       bus_valid,
  output logic [31:0]                bus_wdata,
  output logic                       busy,
  output logic                       finish,
  output logic                       fault
);
  import dcc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } dcc_mv_state_t;

  dcc_mv_state_t state;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state     <= ST_IDLE;
      bus_req   <= '0;
      bus_valid <= 1'b0;
      bus_wdata <= 32'h0;
      finish    <= 1'b0;
      fault     <= 1'b0;
    end else begin
      finish <= 1'b0;
      fault  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            bus_req   <= '{addr: src_addr, width: src_width, write: 1'b0};
            bus_valid <= 1'b1;
            state     <= ST_READ;
          end
        end
        ST_READ: begin
          if (bus_ack) begin
            if (bus_err) begin
              bus_valid <= 1'b0;
              fault     <= 1'b1; // R25
              state     <= ST_IDLE;
            end else begin
              bus_req   <= '{addr: dst_addr, width: dst_width, write: 1'b1};
              bus_wdata <= bus_rdata;
              state     <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (bus_ack) begin
            bus_valid <= 1'b0;
            fault     <= bus_err; // R25
            finish    <= ~bus_err;
            state     <= ST_IDLE;
          end
        end
        default: begin
          state     <= ST_IDLE;
          bus_valid <= 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    busy = (state != ST_IDLE);
  end
endmodule

//--- bench/dcc_channel_sva.sv
/*
 dcc_channel_sva: port-level checks of one dma channel.
 assumes it is bound to dcc_channel and sees only that module's ports.
*/
`timescale 1ns/1ps
module dcc_channel_sva (
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire logic [4:0]            reg_addr,
  input wire logic [31:0]           reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [31:0]           reg_rdata,
  input wire logic                  bus_ack,
  input wire logic                  bus_err,
  input dcc_pkg::dcc_bus_req_t      bus_req,
  input wire logic                  bus_valid,
  input wire logic                  chan_request,
  input wire logic [1:0]            channel_priority
);
  import dcc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  cfg_reserved_a: assert property (reg_rd && reg_addr == 5'h00 |=> reg_rdata[31:15] == 17'h0)
    else $error("config reserved bits read nonzero");
  cnt_reserved_a: assert property (reg_rd && reg_addr == 5'h04 |=> reg_rdata[31:16] == 16'h0)
    else $error("count upper bits read nonzero");
  cfg_readback_a: assert property ((reg_wr && reg_addr == 5'h00) ##1 (reg_rd && reg_addr == 5'h00)
    |=> reg_rdata[14:1] == $past(reg_wdata[14:1], 2)) else $error("config fields not read back");
  prio_copy_a: assert property (reg_wr && reg_addr == 5'h00 |=> ##1
    channel_priority == $past(reg_wdata[13:12], 2)) else $error("priority output mismatch");
  align_half_a: assert property (bus_valid && bus_req.width == W16 |-> !bus_req.addr[0])
    else $error("halfword access not aligned");
  align_word_a: assert property (bus_valid && bus_req.width == W32 |-> bus_req.addr[1:0] == 2'h0)
    else $error("word access not aligned");
  width_code_a: assert property (bus_valid |-> bus_req.width != 2'h3)
    else $error("reserved width on bus");
  fault_stop_a: assert property (bus_valid && bus_ack && bus_err |=> !bus_valid [*4])
    else $error("bus activity after failed access");
  write_next_a: assert property (bus_valid && bus_ack && !bus_err && !bus_req.write
    |-> ##[1:3] bus_valid && bus_req.write) else $error("write phase missing after read");
  // mid-element the mover may still finish, so only the request line is judged
  off_quiet_a: assert property (reg_wr && reg_addr == 5'h00 && !reg_wdata[0] |=> ##1 !chan_request)
    else $error("request while disabled");
endmodule

//--- bench/dcc_bus_model.sv
/*
 dcc_bus_model: system bus slave standing for memory and peripherals.
 assumes one access at a time; answers after lag cycles, fail marks answers as errors.
*/
`timescale 1ns/1ps
module dcc_bus_model (
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire logic [3:0]            lag,
  input wire logic                  fail,
  input dcc_pkg::dcc_bus_req_t      bus_req,
  input wire logic                  bus_valid,
  output logic                      bus_ack,
  output logic                      bus_err,
  output logic [31:0]               bus_rdata
);
  import dcc_pkg::*;
  logic [3:0]  wait_cnt;
  logic [31:0] word;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (bus_valid && !bus_ack && wait_cnt >= lag) begin
      bus_ack <= 1'b1;
      wait_cnt <= 4'h0;
    end else begin
      bus_ack <= 1'b0;
      wait_cnt <= (bus_valid && !bus_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end

  // data outside the answer cycle is inverted so stale values never look right
  assign word = bus_req.addr ^ 32'ha5a5_0000;
  assign bus_rdata = bus_ack ? word : ~word;
  assign bus_err = bus_ack && fail;
endmodule

//--- bench/dcc_channel_bench.sv
/*
 dcc_channel_bench: register-level tests of one dma channel against a bus model.
 assumes the design files and dcc_pkg are compiled first.
*/
`timescale 1ns/1ps
module dcc_channel_bench;
  import dcc_pkg::*;
  logic                 core_clk;
  logic                 rst;
  logic [4:0]           reg_addr;
  logic [31:0]          reg_wdata;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [31:0]          reg_rdata;
  logic                 periph_req;
  logic                 grant;
  logic                 bus_ack;
  logic                 bus_err;
  logic [31:0]          bus_rdata;
  logic [31:0]          bus_wdata;
  dcc_bus_req_t         bus_req;
  logic                 bus_valid;
  logic                 chan_request;
  logic [1:0]           channel_priority;
  logic                 irq;
  logic [3:0]           lag;
  logic                 fail;
  int                   err_total;
  int                   checks;
  logic [31:0]          wr_log[$];
  logic [31:0]          rd_log[$];
  logic [31:0]          wd_log[$];

  dcc_channel u_dcc_channel (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req), .grant(grant),
    .bus_ack(bus_ack), .bus_err(bus_err), .bus_rdata(bus_rdata), .bus_req(bus_req), .bus_valid(bus_valid),
    .bus_wdata(bus_wdata), .chan_request(chan_request), .channel_priority(channel_priority), .irq(irq));
  dcc_bus_model u_dcc_bus_model (.core_clk(core_clk), .rst(rst), .lag(lag), .fail(fail), .bus_req(bus_req),
    .bus_valid(bus_valid), .bus_ack(bus_ack), .bus_err(bus_err), .bus_rdata(bus_rdata));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // completed accesses, split by phase
  always @(posedge core_clk) begin
    if (bus_valid && bus_ack && !bus_err && bus_req.write) wr_log.push_back(bus_req.addr);
    if (bus_valid && bus_ack && !bus_err && bus_req.write) wd_log.push_back(bus_wdata);
    if (bus_valid && bus_ack && !bus_err && !bus_req.write) rd_log.push_back(bus_req.addr);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // strobes stay high until the next task or idle, so writes may run back to back
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask

  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, exp);
    @(posedge core_clk);
  endtask

  task automatic wait_wr(input int n);
    idle(1);
    for (int i = 0; i < 2000 && wr_log.size() < n; i++) @(posedge core_clk);
    chk(32'(wr_log.size()), 32'(n));
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    conclude;
  end

  initial begin
    rst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, periph_req, grant, lag, fail} = '0;
    err_total = 0;
    checks = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    grant <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 7; i++) rchk(5'(i * 4), 32'h0);
    $display("test reset values done");
    for (int p = 0; p < 4; p++) begin
      wr(5'h00, 32'hffff_cffe | (32'(p) << 12));
      rchk(5'h00, 32'h0000_4ffe | (32'(p) << 12));
      chk({30'h0, channel_priority}, 32'(p));
    end
    wr(5'h04, 32'h1234_ffff);
    rchk(5'h04, 32'h0000_ffff);
    $display("test config fields done");
    wr(5'h08, 32'h0000_0103);
    wr(5'h0c, 32'h0000_2001);
    wr(5'h04, 32'h4);
    wr(5'h00, 32'h0000_0687);
    idle(20);
    chk(32'(wr_log.size()), 32'h0);
    periph_req <= 1'b1;
    wait_wr(4);
    idle(20);
    chk(32'(wr_log.size()), 32'h4);
    chk(wr_log[0], 32'h2000);
    chk(wr_log[3], 32'h2006);
    chk(rd_log[3], 32'h0100);
    chk(wd_log[0], 32'ha5a5_0100);
    rchk(5'h04, 32'h0);
    wr(5'h04, 32'h5);
    rchk(5'h04, 32'h0);
    rchk(5'h10, 32'h7);
    chk({31'h0, irq}, 32'h1);
    wr(5'h14, 32'h0);
    rchk(5'h10, 32'h7);
    wr(5'h14, 32'h2);
    rchk(5'h10, 32'h5);
    wr(5'h14, 32'h1);
    rchk(5'h10, 32'h0);
    chk({31'h0, irq}, 32'h0);
    periph_req <= 1'b0;
    wr(5'h00, 32'h0);
    $display("test peripheral to memory done");
    wr_log.delete();
    rd_log.delete();
    lag <= 4'h3;
    wr(5'h08, 32'h0000_0300);
    wr(5'h0c, 32'h0000_0400);
    wr(5'h04, 32'h3);
    wr(5'h00, 32'h0000_4071);
    wait_wr(4);
    chk(wr_log[0], 32'h0300);
    chk(wr_log[2], 32'h0302);
    chk(wr_log[3], 32'h0300);
    chk(rd_log[1], 32'h0400);
    wr(5'h00, 32'h0);
    idle(20);
    lag <= 4'h0;
    wr(5'h04, 32'h0);
    periph_req <= 1'b1;
    wr(5'h00, 32'h1);
    wr_log.delete();
    idle(30);
    chk(32'(wr_log.size()), 32'h0);
    periph_req <= 1'b0;
    wr(5'h00, 32'h0);
    $display("test circular memory to memory done");
    fail <= 1'b1;
    wr(5'h14, 32'h1);
    wr(5'h08, 32'h0000_0500);
    wr(5'h04, 32'h2);
    wr(5'h00, 32'h0000_4009);
    idle(30);
    rchk(5'h00, 32'h0000_4008);
    rchk(5'h10, 32'h9);
    chk({31'h0, irq}, 32'h1);
    fail <= 1'b0;
    wr(5'h14, 32'h1);
    rchk(5'h10, 32'h0);
    $display("test bus fault done");
    conclude;
  end
endmodule

bind dcc_channel dcc_channel_sva u_dcc_channel_sva (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_ack(bus_ack),
  .bus_err(bus_err), .bus_req(bus_req), .bus_valid(bus_valid), .chan_request(chan_request),
  .channel_priority(channel_priority));
